// [common/spf_params.svh]
// Constants for the strap and pin function select block.
// Assumes a single 100 MHz core clock and a plain register port.
//
// Overview of operation
// RULE1 - Clock-run strap 0 disables clock-run support, 1 enables it.
// RULE2 - Arbiter strap 0 selects internal arbiter, 1 defers to external arbiter.
// RULE3 - General pin n direction comes from control register bit n.
// RULE4 - Pin 0 becomes the clock-run input while clock-run mode is on.
// RULE5 - Pin 1 becomes power-override output when field 22:20 is 001b or 011b.
// RULE6 - Board holds pin 2 high at reset release for compatibility mode.
// RULE7 - Pull-up on serial data pin makes pins 4 and 5 the serial bus.
// RULE8 - Pull-down on serial data pin keeps pins 4 and 5 general purpose.
// RULE9 - Straps and pull detection are sampled once at reset release and held.
`ifndef SPF_PARAMS_SVH
`define SPF_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SPF_ADDR_GP_CTRL 8'h00
`define SPF_ADDR_GP_OUT 8'h04
`define SPF_ADDR_GEN_CTRL 8'h08
`define SPF_ADDR_STATUS 8'h0C
`define SPF_ADDR_GP_IN 8'h10

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SPF_NUM_PINS 6
`define SPF_OVRD_LSB 20
`define SPF_OVRD_MSB 22
`define SPF_OVRD_MODE_A 3'h1
`define SPF_OVRD_MODE_B 3'h3
`define SPF_GP_CTRL_RST 6'h00
`define SPF_GP_OUT_RST 6'h00
`define SPF_GEN_CTRL_RST 32'h00000000

`endif

// [common/spf_pkg.sv]
// Types for the strap and pin function select block.
// Assumes nothing beyond the constants header.
package spf_pkg;
  typedef enum logic [1:0] {
    SPF_IN_RESET,
    SPF_SAMPLE,
    SPF_RUN
  } spf_state_t;
endpackage

// [core/spf_pin_select.sv]
// Function select for the six multi-purpose pins and two straps.
// Assumes synchronous pin inputs and a master that never waits.
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/10ps
`include "spf_params.svh"

module spf_pin_select (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Straps
  input wire logic clock_run_strap_i,
  input wire logic outside_arbiter_strap_i,
  // General pins, output enable low while driving
  input wire logic [5:0] general_pin_i,
  output logic [5:0] general_pin_o,
  output logic [5:0] general_pin_oe_n_o,
  // Selected functions
  output logic clock_run_enable_o,
  output logic outside_arbiter_o,
  output logic clock_run_pin_o,
  input wire logic power_override_out_i,
  output logic compat_mode_o,
  output logic serial_bus_enable_o,
  input wire logic serial_clock_drive_low_i,
  input wire logic serial_data_drive_low_i,
  output logic serial_clock_in_o,
  output logic serial_data_in_o
);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  spf_pkg::spf_state_t state;
  spf_pkg::spf_state_t next_state;
  logic clock_run_enable;
  logic next_clock_run_enable;
  logic outside_arbiter;
  logic next_outside_arbiter;
  logic compat_mode;
  logic next_compat_mode;
  logic serial_bus_enable;
  logic next_serial_bus_enable;

  always_comb
  begin
    next_state = state;
    next_clock_run_enable = clock_run_enable;
    next_outside_arbiter = outside_arbiter;
    next_compat_mode = compat_mode;
    next_serial_bus_enable = serial_bus_enable;
    unique case (state)
      spf_pkg::SPF_IN_RESET:
      begin
        next_state = spf_pkg::SPF_SAMPLE;
      end
      spf_pkg::SPF_SAMPLE:
      begin
        // All pins are released here, so the board pulls are seen
        next_clock_run_enable = clock_run_strap_i; // see RULE1, see RULE9
        next_outside_arbiter = outside_arbiter_strap_i; // see RULE2, see RULE9
        next_compat_mode = general_pin_i[2]; // see RULE6
        next_serial_bus_enable = general_pin_i[5]; // see RULE7, see RULE8, see RULE9
        next_state = spf_pkg::SPF_RUN;
      end
      spf_pkg::SPF_RUN:
      begin
        next_state = spf_pkg::SPF_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state <= spf_pkg::SPF_IN_RESET;
      clock_run_enable <= 1'b0;
      outside_arbiter <= 1'b0;
      compat_mode <= 1'b0;
      serial_bus_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      clock_run_enable <= next_clock_run_enable;
      outside_arbiter <= next_outside_arbiter;
      compat_mode <= next_compat_mode;
      serial_bus_enable <= next_serial_bus_enable;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [5:0] gp_ctrl;
  logic [5:0] next_gp_ctrl;
  logic [5:0] gp_out;
  logic [5:0] next_gp_out;
  logic [31:0] gen_ctrl;
  logic [31:0] next_gen_ctrl;
  logic power_override_sel;

  always_comb
  begin
    next_gp_ctrl = gp_ctrl;
    next_gp_out = gp_out;
    next_gen_ctrl = gen_ctrl;
    if (reg_wr_i)
    begin
      if (reg_addr_i == `SPF_ADDR_GP_CTRL)
      begin
        next_gp_ctrl = reg_wdata_i[5:0]; // see RULE3
      end
      if (reg_addr_i == `SPF_ADDR_GP_OUT)
      begin
        next_gp_out = reg_wdata_i[5:0];
      end
      if (reg_addr_i == `SPF_ADDR_GEN_CTRL)
      begin
        next_gen_ctrl = reg_wdata_i; // see RULE5
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      gp_ctrl <= `SPF_GP_CTRL_RST;
      gp_out <= `SPF_GP_OUT_RST;
      gen_ctrl <= `SPF_GEN_CTRL_RST;
    end
    else
    begin
      gp_ctrl <= next_gp_ctrl;
      gp_out <= next_gp_out;
      gen_ctrl <= next_gen_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  logic [5:0] gp_in;

  // Captured selections, read back by software
  assign status_word = {28'h0000000, serial_bus_enable, compat_mode,
    outside_arbiter, clock_run_enable};

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        `SPF_ADDR_GP_CTRL:
        begin
          next_rdata = {26'h0000000, gp_ctrl};
        end
        `SPF_ADDR_GP_OUT:
        begin
          next_rdata = {26'h0000000, gp_out};
        end
        `SPF_ADDR_GEN_CTRL:
        begin
          next_rdata = gen_ctrl;
        end
        `SPF_ADDR_STATUS:
        begin
          next_rdata = status_word; // see RULE9
        end
        `SPF_ADDR_GP_IN:
        begin
          next_rdata = {26'h0000000, gp_in};
        end
        default:
        begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata <= 32'h00000000;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  assign reg_rdata_o = rdata;

  // ----------------------------------------------------------------
  // Pin function multiplexing
  // ----------------------------------------------------------------
  // Pin 1 hand-over to the power-override output
  assign power_override_sel =
    (gen_ctrl[`SPF_OVRD_MSB:`SPF_OVRD_LSB] == `SPF_OVRD_MODE_A) ||
    (gen_ctrl[`SPF_OVRD_MSB:`SPF_OVRD_LSB] == `SPF_OVRD_MODE_B); // see RULE5

  genvar n;
  generate
    for (n = 0; n < `SPF_NUM_PINS; n = n + 1)
    begin : g_pin
      logic special;
      logic drive_val;
      logic drive_en;
      logic pin_out;
      logic pin_oe_n;
      logic pin_in;
      if (n == 0)
      begin : g_p0
        // Clock-run input, never driven
        assign special = clock_run_enable; // see RULE4
        assign drive_val = 1'b0;
        assign drive_en = 1'b0;
      end
      else if (n == 1)
      begin : g_p1
        // Power-override output, always driven
        assign special = power_override_sel; // see RULE5
        assign drive_val = power_override_out_i;
        assign drive_en = 1'b1;
      end
      else if (n == 4)
      begin : g_p4
        // Serial clock, pulled low or released
        assign special = serial_bus_enable; // see RULE7, see RULE8
        assign drive_val = 1'b0;
        assign drive_en = serial_clock_drive_low_i;
      end
      else if (n == 5)
      begin : g_p5
        // Serial data, pulled low or released
        assign special = serial_bus_enable; // see RULE7, see RULE8
        assign drive_val = 1'b0;
        assign drive_en = serial_data_drive_low_i;
      end
      else
      begin : g_plain
        assign special = 1'b0;
        assign drive_val = 1'b0;
        assign drive_en = 1'b0;
      end
      // Pins stay released until the straps have been captured
      always_comb
      begin
        pin_out = gp_out[n];
        pin_oe_n = 1'b1;
        pin_in = general_pin_i[n];
        if (special)
        begin
          pin_out = drive_val;
          pin_in = 1'b0;
        end
        if (state == spf_pkg::SPF_RUN)
        begin
          if (special)
          begin
            pin_oe_n = ~drive_en;
          end
          else
          begin
            pin_oe_n = ~gp_ctrl[n]; // see RULE3
          end
        end
      end
      assign general_pin_o[n] = pin_out;
      assign general_pin_oe_n_o[n] = pin_oe_n;
      assign gp_in[n] = pin_in;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Function outputs
  // ----------------------------------------------------------------
  // Captured selections
  assign clock_run_enable_o = clock_run_enable;
  assign outside_arbiter_o = outside_arbiter;
  assign compat_mode_o = compat_mode;
  assign serial_bus_enable_o = serial_bus_enable;

  // Inputs passed on to the selected functions
  assign clock_run_pin_o = clock_run_enable ? general_pin_i[0] : 1'b1; // see RULE4
  assign serial_clock_in_o = serial_bus_enable ? general_pin_i[4] : 1'b1;
  assign serial_data_in_o = serial_bus_enable ? general_pin_i[5] : 1'b1;

endmodule

// [verification/spf_checker.sv]
// Assertions on the pin function select ports.
// Assumes binding to spf_pin_select.
`timescale 1ns/10ps
module spf_checker (
  input wire logic clk_sys_i, resetn_i, reg_rd_i, clock_run_strap_i, outside_arbiter_strap_i,
  input wire logic serial_clock_drive_low_i, serial_data_drive_low_i,
  input wire logic [5:0] general_pin_i, general_pin_oe_n_o,
  input wire logic [31:0] reg_rdata_o,
  input wire logic clock_run_enable_o, outside_arbiter_o, clock_run_pin_o, compat_mode_o,
  input wire logic serial_bus_enable_o, serial_clock_in_o, serial_data_in_o
);
  logic [1:0] cnt;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i) cnt <= 2'h0;
    else if (cnt != 2'h3) cnt <= cnt + 2'h1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  chk_strap_take: assert property (cnt == 2'h1 |=>
    {clock_run_enable_o, outside_arbiter_o} == $past({clock_run_strap_i, outside_arbiter_strap_i}))
    else $error("strap capture wrong");
  chk_pull_take: assert property (cnt == 2'h1 |=>
    {serial_bus_enable_o, compat_mode_o} == $past({general_pin_i[5], general_pin_i[2]}))
    else $error("pull capture wrong");
  chk_flags_held: assert property (cnt == 2'h3 && $past(cnt) == 2'h3 |->
    $stable({clock_run_enable_o, outside_arbiter_o, serial_bus_enable_o, compat_mode_o}))
    else $error("flags moved");
  chk_pins_idle: assert property (cnt < 2'h2 |-> general_pin_oe_n_o == 6'h3F)
    else $error("pin driven early");
  chk_run_pin: assert property (clock_run_enable_o |->
    clock_run_pin_o == general_pin_i[0] && general_pin_oe_n_o[0]) else $error("clock run pin");
  chk_run_off: assert property (!clock_run_enable_o |-> clock_run_pin_o)
    else $error("clock run active");
  chk_ser_in: assert property (serial_bus_enable_o |->
    {serial_data_in_o, serial_clock_in_o} == general_pin_i[5:4]) else $error("serial in");
  chk_ser_drive: assert property (serial_bus_enable_o |-> general_pin_oe_n_o[5:4] ==
    ~{serial_data_drive_low_i, serial_clock_drive_low_i}) else $error("serial drive");
  chk_ser_off: assert property (cnt == 2'h3 && !serial_bus_enable_o |->
    serial_clock_in_o && serial_data_in_o) else $error("serial not idle");
  chk_rd_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0) else $error("stray rdata");
  cover property (cnt == 2'h1 && clock_run_strap_i);
  cover property (serial_bus_enable_o && serial_clock_drive_low_i);
  cover property (reg_rd_i);
  cover property (clock_run_enable_o && !general_pin_i[0]);
endmodule
bind spf_pin_select spf_checker chk_i (
  .clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i),
  .reg_rd_i(reg_rd_i),
  .clock_run_strap_i(clock_run_strap_i),
  .outside_arbiter_strap_i(outside_arbiter_strap_i),
  .serial_clock_drive_low_i(serial_clock_drive_low_i),
  .serial_data_drive_low_i(serial_data_drive_low_i),
  .general_pin_i(general_pin_i),
  .general_pin_oe_n_o(general_pin_oe_n_o),
  .reg_rdata_o(reg_rdata_o),
  .clock_run_enable_o(clock_run_enable_o),
  .outside_arbiter_o(outside_arbiter_o),
  .clock_run_pin_o(clock_run_pin_o),
  .compat_mode_o(compat_mode_o),
  .serial_bus_enable_o(serial_bus_enable_o),
  .serial_clock_in_o(serial_clock_in_o),
  .serial_data_in_o(serial_data_in_o)
);

// [verification/spf_board_model.sv]
// Board model: compat strap, serial-bus pull and outside levels on free pins.
// Assumes a pin is driven while its enable is low.
`timescale 1ns/10ps
module spf_board_model (
  input wire logic pull_up_i,
  input wire logic compat_i,
  input wire logic [3:0] ext_level_i,
  input wire logic [5:0] drive_i,
  input wire logic [5:0] oe_n_i,
  output logic [5:0] level_o
);
  logic [5:0] pull;
  assign pull = {pull_up_i, ext_level_i[3:2], compat_i, ext_level_i[1:0]};
  always_comb
    for (int i = 0; i < 6; i++)
      level_o[i] = oe_n_i[i] ? pull[i] : drive_i[i];
endmodule

// [verification/tb_top.sv]
// Random and corner tests of strap capture and pin functions.
// Assumes the board model drives the pin levels.
`timescale 1ns/10ps
`include "spf_params.svh"
module tb_top;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, wr = 1'b0, rdq = 1'b0, cr = 1'b0, arb = 1'b0;
  logic pwr = 1'b0, scl = 1'b0, sda = 1'b0, pu = 1'b0, cmp = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wd = 32'h0, rdo, d;
  logic [5:0] lvl, po, oe, dir, val, msk;
  logic [3:0] ext = 4'hF;
  logic [2:0] ov;
  int num_errors = 0, tests_run = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  spf_pin_select DUT (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rdq), .reg_rdata_o(rdo),
    .clock_run_strap_i(cr), .outside_arbiter_strap_i(arb), .general_pin_i(lvl),
    .general_pin_o(po), .general_pin_oe_n_o(oe), .clock_run_enable_o(), .outside_arbiter_o(),
    .clock_run_pin_o(), .power_override_out_i(pwr), .compat_mode_o(), .serial_bus_enable_o(),
    .serial_clock_drive_low_i(scl), .serial_data_drive_low_i(sda), .serial_clock_in_o(),
    .serial_data_in_o());
  spf_board_model board (.pull_up_i(pu), .compat_i(cmp), .ext_level_i(ext), .drive_i(po),
    .oe_n_i(oe), .level_o(lvl));
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] v);
    @(posedge clk_sys_i);
    addr <= a;
    wd <= v;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] a);
    @(posedge clk_sys_i);
    addr <= a;
    rdq <= 1'b1;
    @(posedge clk_sys_i);
    rdq <= 1'b0;
    #1 d = rdo;
  endtask
  function automatic logic [5:0] exp_oe(logic [5:0] dr, logic [2:0] f, logic c, logic s);
    exp_oe = ~dr;
    if (c) exp_oe[0] = 1'b1;
    if (f == 3'h1 || f == 3'h3) exp_oe[1] = 1'b0;
    if (s) exp_oe[5:4] = ~{sda, scl};
  endfunction
  function automatic logic [5:0] exp_po(logic [5:0] v, logic [2:0] f, logic s);
    exp_po = v;
    if (f == 3'h1 || f == 3'h3) exp_po[1] = pwr;
    if (s) exp_po[5:4] = 2'h0;
  endfunction
  function automatic logic [5:0] exp_sp(logic [2:0] f, logic c, logic s);
    exp_sp = {s, s, 3'h0, c};
    if (f == 3'h1 || f == 3'h3) exp_sp[1] = 1'b1;
  endfunction
  task automatic report_and_stop;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h1b7eaf07));
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk_sys_i);
      resetn_i <= 1'b0;
      {cr, arb, pu} <= k[2:0];
      cmp <= 1'($urandom);
      repeat (3) @(posedge clk_sys_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      {cr, arb} <= ~k[2:1];
      rd_reg(`SPF_ADDR_STATUS);
      check("status", {28'h0, k[0], cmp, k[1], k[2]}, d);
      for (int j = 0; j < 4; j++)
      begin
        dir = 6'($urandom);
        val = 6'($urandom);
        ov = (j < 2) ? {1'b0, j[0], 1'b1} : 3'($urandom);
        @(posedge clk_sys_i);
        {pwr, scl, sda} <= 3'($urandom);
        ext <= 4'($urandom);
        wr_reg(`SPF_ADDR_GP_CTRL, {26'h0, dir});
        wr_reg(`SPF_ADDR_GP_OUT, {26'h0, val});
        wr_reg(`SPF_ADDR_GEN_CTRL, {9'h0, ov, 20'h0});
        #1 check("oe_n", {26'h0, exp_oe(dir, ov, k[2], k[0])}, {26'h0, oe});
        msk = ~exp_oe(dir, ov, k[2], k[0]);
        check("drive", {26'h0, exp_po(val, ov, k[0]) & msk}, {26'h0, po & msk});
        if (j < 2) check("pwr", {31'h0, pwr}, {31'h0, po[1]});
        rd_reg(`SPF_ADDR_GP_IN);
        check("gp_in", {26'h0, lvl & ~exp_sp(ov, k[2], k[0])}, d);
      end
      rd_reg(8'hFC);
      check("unmapped", 32'h0, d);
      $display("test %0d done", k);
    end
    report_and_stop();
  end
  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end
endmodule
